// >>> hdl/slrh_pkg.sv
// package for the serial link recovery handshake: codes, timings, states
// assumes a single 100 MHz clock and an 8N1 serial line
package slrh_pkg;
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned RECOVERY_BAUD = 9600;
  localparam int unsigned BREAK_DETECT_MS = 100;
  localparam int unsigned HOST_BREAK_MS = 500;
  localparam int unsigned ENQ_PERIOD_MS = 500;
  localparam int unsigned ENQ_WINDOW_S = 10;
  // derived cycle counts; baud divisors round down
  localparam int unsigned BREAK_CYC = (CLK_HZ / 1000) * BREAK_DETECT_MS;
  localparam int unsigned ENQ_PERIOD_CYC = (CLK_HZ / 1000) * ENQ_PERIOD_MS;
  localparam int unsigned ENQ_WINDOW_CYC = CLK_HZ * ENQ_WINDOW_S;
  localparam int unsigned RECOVERY_DIV = CLK_HZ / RECOVERY_BAUD;
  localparam int unsigned BOOT_DIV = CLK_HZ / 38400;
  localparam int DIV_W = 16;
  localparam int TIME_W = 32;
  localparam int BYTE_W = 8;
  localparam int FIFO_DEPTH = 8;
  localparam int FRAME_BITS = 10;
  localparam logic [7:0] CHAR_ENQ = 8'h05;
  localparam logic [7:0] CHAR_ACK = 8'h06;
  localparam logic [7:0] CHAR_LF = 8'h0A;
  localparam logic [3:0] DATA_BITS = 4'h8;
  localparam logic [3:0] LAST_BIT = 4'h9;

  typedef enum logic [1:0] {
    SLRH_NORMAL = 2'b00,
    SLRH_BREAK = 2'b01,
    SLRH_ENQ = 2'b10,
    SLRH_DUMP = 2'b11
  } slrh_state_t;
endpackage : slrh_pkg

// >>> hdl/slrh_stream_if.sv
// valid/ready byte stream between the block's own modules
// assumes source and sink share one clock
`timescale 1ns/1ns
`default_nettype none
interface slrh_stream_if #(parameter int W = 8);
  logic [W-1:0] data;
  logic valid;
  logic ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface : slrh_stream_if
`default_nettype wire

// >>> hdl/slrh_fifo.sv
// small first-in first-out buffer with a registered head word
// assumes one clock; holds DEPTH words plus one in the head register
`timescale 1ns/1ns
`default_nettype none
module slrh_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 8
) (
  input wire logic i_clk,
  input wire logic i_reset,
  slrh_stream_if.snk wr,
  slrh_stream_if.src rd
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wp;
  logic [AW-1:0] rp;
  logic [AW:0] cnt;
  logic [W-1:0] head;
  logic head_valid;
  logic wr_fire;
  logic mem_pop;

  assign wr.ready = (cnt != (AW+1)'(DEPTH));
  assign wr_fire = wr.valid && wr.ready;
  assign mem_pop = (cnt != '0) && (!head_valid || rd.ready);
  assign rd.valid = head_valid;
  assign rd.data = head;

  always_ff @(posedge i_clk) begin
    if (wr_fire) begin
      mem[wp] <= wr.data;
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      wp <= '0;
      rp <= '0;
      cnt <= '0;
    end else begin
      if (wr_fire) begin
        wp <= AW'(wp + 1'b1);
      end
      if (mem_pop) begin
        rp <= AW'(rp + 1'b1);
      end
      cnt <= (AW+1)'(cnt + (AW+1)'(wr_fire) - (AW+1)'(mem_pop));
    end
  end

  // head register keeps the read data coming straight from flip-flops
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      head <= '0;
      head_valid <= 1'b0;
    end else if (mem_pop) begin
      head <= mem[rp];
      head_valid <= 1'b1;
    end else if (rd.ready) begin
      head_valid <= 1'b0;
    end
  end
endmodule : slrh_fifo
`default_nettype wire

// >>> hdl/slrh_top.sv
// serial port with break-triggered recovery handshake
// assumes i_rxd is asynchronous; config dump bytes come from the host system side
`timescale 1ns/1ns
`default_nettype none
module slrh_top #(
  parameter int unsigned P_BREAK_CYC = slrh_pkg::BREAK_CYC,
  parameter int unsigned P_ENQ_PERIOD_CYC = slrh_pkg::ENQ_PERIOD_CYC,
  parameter int unsigned P_WINDOW_CYC = slrh_pkg::ENQ_WINDOW_CYC,
  parameter logic [15:0] P_RECOVERY_DIV = 16'(slrh_pkg::RECOVERY_DIV),
  parameter logic [15:0] P_BOOT_DIV = 16'(slrh_pkg::BOOT_DIV)
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_rxd,
  output logic o_txd,
  input wire logic [7:0] i_tx_data,
  input wire logic i_tx_valid,
  output logic o_tx_ready,
  output logic [7:0] o_rx_data,
  output logic o_rx_valid,
  input wire logic [7:0] i_cfg_data,
  input wire logic i_cfg_valid,
  output logic o_cfg_ready,
  input wire logic [15:0] i_baud_div,
  input wire logic i_baud_load,
  output logic [15:0] o_baud_div,
  output logic o_recovery
);
  localparam int DW = slrh_pkg::DIV_W;
  localparam int TW = slrh_pkg::TIME_W;

  slrh_pkg::slrh_state_t state;
  slrh_pkg::slrh_state_t next_state;
  slrh_stream_if #(.W(slrh_pkg::BYTE_W)) fin ();
  slrh_stream_if #(.W(slrh_pkg::BYTE_W)) fout ();

  logic s1, s2, s3, rx_lvl;
  logic [TW-1:0] low_cnt;
  logic break_det;
  logic [TW-1:0] enq_cnt;
  logic [TW-1:0] win_cnt;
  logic enq_due;
  logic [DW-1:0] baud_div;
  logic [DW-1:0] pend_div;
  logic pend;
  logic tx_busy;
  logic [9:0] tx_sh;
  logic [3:0] tx_bit;
  logic [DW-1:0] tx_cnt;
  logic tx_load;
  logic [7:0] tx_byte;
  logic rx_busy;
  logic [3:0] rx_bit;
  logic [DW-1:0] rx_cnt;
  logic [7:0] rx_sh;
  logic rx_done;
  logic ack_seen;

  // ******************************************************
  // buffer for normal outgoing data
  // ******************************************************
  assign fin.data = i_tx_data;
  assign fin.valid = i_tx_valid;
  assign o_tx_ready = fin.ready;

  slrh_fifo #(.W(slrh_pkg::BYTE_W), .DEPTH(slrh_pkg::FIFO_DEPTH)) u_fifo (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .wr(fin),
    .rd(fout)
  );

  // ******************************************************
  // line input synchroniser and break detection
  // ******************************************************
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      s1 <= 1'b1;
      s2 <= 1'b1;
      s3 <= 1'b1;
      rx_lvl <= 1'b1;
    end else begin
      s1 <= i_rxd;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        rx_lvl <= s3;
      end
    end
  end

  // a break is a spacing line held far longer than any character
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      low_cnt <= '0;
    end else if (rx_lvl) begin
      low_cnt <= '0;
    end else if (low_cnt != TW'(P_BREAK_CYC)) begin
      low_cnt <= TW'(low_cnt + 1'b1);
    end
  end
  assign break_det = (low_cnt == TW'(P_BREAK_CYC));

  // ******************************************************
  // recovery sequence
  // ******************************************************
  assign ack_seen = rx_done && (rx_sh == slrh_pkg::CHAR_ACK);

  always_comb begin
    next_state = state;
    unique case (state)
      slrh_pkg::SLRH_NORMAL: begin
        if (break_det) begin
          next_state = slrh_pkg::SLRH_BREAK;
        end
      end
      slrh_pkg::SLRH_BREAK: begin
        if (rx_lvl) begin
          next_state = slrh_pkg::SLRH_ENQ;
        end
      end
      slrh_pkg::SLRH_ENQ: begin
        if (break_det) begin
          next_state = slrh_pkg::SLRH_BREAK;
        end else if (ack_seen) begin
          next_state = slrh_pkg::SLRH_DUMP;
        end else if (win_cnt == TW'(P_WINDOW_CYC) && !tx_busy) begin
          next_state = slrh_pkg::SLRH_NORMAL;
        end
      end
      slrh_pkg::SLRH_DUMP: begin
        if (tx_load && tx_byte == slrh_pkg::CHAR_LF) begin
          next_state = slrh_pkg::SLRH_NORMAL;
        end
      end
    endcase
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      state <= slrh_pkg::SLRH_NORMAL;
    end else begin
      state <= next_state;
    end
  end

  // enquiry pacing and window; first enquiry goes out at once
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      enq_cnt <= '0;
      win_cnt <= '0;
      enq_due <= 1'b0;
    end else if (state != slrh_pkg::SLRH_ENQ) begin
      enq_cnt <= '0;
      win_cnt <= '0;
      enq_due <= 1'b1;
    end else begin
      if (win_cnt != TW'(P_WINDOW_CYC)) begin
        win_cnt <= TW'(win_cnt + 1'b1);
      end
      if (enq_cnt == TW'(P_ENQ_PERIOD_CYC - 1)) begin
        enq_cnt <= '0;
      end else begin
        enq_cnt <= TW'(enq_cnt + 1'b1);
      end
      // set wins over the clear by the transmitter
      if (enq_cnt == TW'(P_ENQ_PERIOD_CYC - 1)) begin
        enq_due <= 1'b1;
      end else if (tx_load) begin
        enq_due <= 1'b0;
      end
    end
  end

  // ******************************************************
  // baud rate control
  // ******************************************************
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      baud_div <= P_BOOT_DIV;
      pend_div <= '0;
      pend <= 1'b0;
    end else begin
      if (break_det) begin
        baud_div <= P_RECOVERY_DIV;
        pend <= 1'b0;
      end else if (i_baud_load) begin
        pend_div <= i_baud_div;
        pend <= 1'b1;
      end else if (pend && state == slrh_pkg::SLRH_NORMAL && !tx_busy && !fout.valid) begin
        // queued reply drains at the old rate first; a steady stream delays the switch
        baud_div <= pend_div;
        pend <= 1'b0;
      end
    end
  end
  assign o_baud_div = baud_div;
  assign o_recovery = (state != slrh_pkg::SLRH_NORMAL);

  // ******************************************************
  // transmitter, 8N1, source chosen by state
  // ******************************************************
  always_comb begin
    tx_load = 1'b0;
    tx_byte = fout.data;
    unique case (state)
      slrh_pkg::SLRH_NORMAL: begin
        tx_load = !tx_busy && fout.valid;
      end
      slrh_pkg::SLRH_BREAK: begin
        tx_load = 1'b0;
      end
      slrh_pkg::SLRH_ENQ: begin
        tx_byte = slrh_pkg::CHAR_ENQ;
        tx_load = !tx_busy && enq_due && win_cnt != TW'(P_WINDOW_CYC);
      end
      slrh_pkg::SLRH_DUMP: begin
        tx_byte = i_cfg_data;
        tx_load = !tx_busy && i_cfg_valid;
      end
    endcase
  end
  assign fout.ready = (state == slrh_pkg::SLRH_NORMAL) && !tx_busy;
  assign o_cfg_ready = (state == slrh_pkg::SLRH_DUMP) && !tx_busy;

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      tx_busy <= 1'b0;
      tx_sh <= '1;
      tx_bit <= '0;
      tx_cnt <= '0;
    end else if (tx_load) begin
      tx_busy <= 1'b1;
      tx_sh <= {1'b1, tx_byte, 1'b0};
      tx_bit <= '0;
      tx_cnt <= '0;
    end else if (tx_busy) begin
      if (tx_cnt == DW'(baud_div - 1'b1)) begin
        tx_cnt <= '0;
        tx_sh <= {1'b1, tx_sh[9:1]};
        tx_bit <= 4'(tx_bit + 1'b1);
        if (tx_bit == slrh_pkg::LAST_BIT) begin
          tx_busy <= 1'b0;
        end
      end else begin
        tx_cnt <= DW'(tx_cnt + 1'b1);
      end
    end
  end
  assign o_txd = tx_busy ? tx_sh[0] : 1'b1;

  // ******************************************************
  // receiver, 8N1; bytes with a bad stop bit are dropped
  // ******************************************************
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      rx_busy <= 1'b0;
      rx_bit <= '0;
      rx_cnt <= '0;
      rx_sh <= '0;
      rx_done <= 1'b0;
    end else begin
      rx_done <= 1'b0;
      if (!rx_busy) begin
        if (!rx_lvl && low_cnt == '0 + TW'(1)) begin
          rx_busy <= 1'b1;
          rx_bit <= '0;
          rx_cnt <= DW'(baud_div >> 1);
        end
      end else if (rx_cnt == DW'(baud_div - 1'b1)) begin
        rx_cnt <= '0;
        rx_bit <= 4'(rx_bit + 1'b1);
        if (rx_bit == '0 && rx_lvl) begin
          rx_busy <= 1'b0;
        end else if (rx_bit != '0 && rx_bit <= slrh_pkg::DATA_BITS) begin
          rx_sh <= {rx_lvl, rx_sh[7:1]};
        end else if (rx_bit == slrh_pkg::LAST_BIT) begin
          rx_busy <= 1'b0;
          rx_done <= rx_lvl;
        end
      end else begin
        rx_cnt <= DW'(rx_cnt + 1'b1);
      end
    end
  end

  // commands reach the user only in normal operation; end marker is theirs to find
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_rx_data <= '0;
      o_rx_valid <= 1'b0;
    end else begin
      o_rx_valid <= rx_done && state == slrh_pkg::SLRH_NORMAL;
      if (rx_done) begin
        o_rx_data <= rx_sh;
      end
    end
  end
endmodule : slrh_top
`default_nettype wire

// >>> testbench/slrh_chk.sv
// checker on the recovery handshake top's ports
// assumes bind into slrh_top with its count parameters
`timescale 1ns/1ns
`default_nettype none
module slrh_chk #(
  parameter int unsigned P_BREAK_CYC = 200,
  parameter int unsigned P_WINDOW_CYC = 50000,
  parameter logic [15:0] P_RECOVERY_DIV = 16'h0010
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_rxd,
  input wire logic o_txd,
  input wire logic o_tx_ready,
  input wire logic o_rx_valid,
  input wire logic [7:0] i_cfg_data,
  input wire logic i_cfg_valid,
  input wire logic o_cfg_ready,
  input wire logic [15:0] o_baud_div,
  input wire logic o_recovery
);
  // ****
  // line counters
  // ****
  localparam int LF_MAX = 12 * P_RECOVERY_DIV;
  int unsigned lo_cnt;
  int unsigned hi_cnt;
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) lo_cnt <= 0;
    else lo_cnt <= i_rxd ? 0 : lo_cnt + 1;
  end
  // window runs from line release; margin for the input synchroniser
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) hi_cnt <= 0;
    else hi_cnt <= (!o_recovery || !i_rxd) ? 0 : hi_cnt + 1;
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);
  a_break_rate: assert property (lo_cnt == P_BREAK_CYC + 8 |->
    o_recovery && o_baud_div == P_RECOVERY_DIV) else $error("break missed");
  a_recov_rate: assert property (o_recovery && $past(o_recovery) |->
    o_baud_div == P_RECOVERY_DIV) else $error("recovery rate lost");
  a_recov_quiet: assert property (o_recovery |-> !o_rx_valid)
    else $error("rx during recovery");
  a_exit_rate: assert property ($fell(o_recovery) |->
    o_baud_div == P_RECOVERY_DIV) else $error("exit rate");
  a_dump_gate: assert property (o_cfg_ready |-> o_recovery && o_txd)
    else $error("dump outside recovery");
  a_lf_ends: assert property (i_cfg_valid && o_cfg_ready && i_cfg_data == 8'h0A
    |-> ##[1:LF_MAX] !o_recovery) else $error("dump did not end");
  a_rate_idle: assert property ($changed(o_baud_div) && !o_recovery |->
    $past(o_txd) && o_txd && o_tx_ready) else $error("rate change mid frame");
  a_window_end: assert property (hi_cnt <= P_WINDOW_CYC + 40)
    else $error("window overrun");
endmodule : slrh_chk
bind slrh_top slrh_chk #(.P_BREAK_CYC(P_BREAK_CYC), .P_WINDOW_CYC(P_WINDOW_CYC),
  .P_RECOVERY_DIV(P_RECOVERY_DIV)) chk_u (.i_clk(i_clk), .i_reset(i_reset),
  .i_rxd(i_rxd), .o_txd(o_txd), .o_tx_ready(o_tx_ready), .o_rx_valid(o_rx_valid),
  .i_cfg_data(i_cfg_data), .i_cfg_valid(i_cfg_valid), .o_cfg_ready(o_cfg_ready),
  .o_baud_div(o_baud_div), .o_recovery(o_recovery));
`default_nettype wire

// >>> testbench/slrh_host.sv
// host model on the serial pins: break, send, decode
// assumes 8N1 and a divisor in clock cycles per bit
`timescale 1ns/1ns
`default_nettype none
module slrh_host (
  input wire logic i_clk,
  input wire logic i_txd,
  output logic o_rxd
);
  int div = 8;
  logic [7:0] got[$];
  initial o_rxd = 1'b1;
  // ****
  // line tasks
  // ****
  task automatic brk(input int n);
    o_rxd <= 1'b0;
    repeat (n) @(posedge i_clk);
    o_rxd <= 1'b1;
  endtask : brk
  // command byte streams end in a line feed sent by the caller; the ACK goes alone
  task automatic put(input logic [7:0] d);
    logic [9:0] f;
    f = {1'b1, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      o_rxd <= f[i];
      repeat (div) @(posedge i_clk);
    end
  endtask : put
  always begin
    logic [7:0] b;
    @(negedge i_txd);
    repeat (div / 2) @(posedge i_clk);
    for (int i = 0; i < 9; i++) begin
      repeat (div) @(posedge i_clk);
      if (i < 8) b[i] = i_txd;
    end
    // bad stop bit drops the frame
    if (i_txd === 1'b1) got.push_back(b);
  end
endmodule : slrh_host
`default_nettype wire

// >>> testbench/test_serial_link_recovery_handshake.sv
// self-checking bench for the recovery handshake top
// assumes the host model on the pins and the bound checker
`timescale 1ns/1ns
`default_nettype none
module test_serial_link_recovery_handshake;
  localparam int BRK = 200;
  localparam int PER = 2000;
  localparam int WIN = 50000;
  logic i_clk, i_reset, i_rxd, o_txd, i_tx_valid, o_tx_ready, o_rx_valid;
  logic i_cfg_valid, o_cfg_ready, i_baud_load, o_recovery;
  logic [7:0] i_tx_data, o_rx_data, i_cfg_data, b;
  logic [15:0] i_baud_div, o_baud_div, nd;
  logic [7:0] exp_q[$];
  logic [7:0] rx_q[$];
  int n_mismatch = 0;
  int n_compared = 0;
  int n_cfg = 0;
  int n;
  time t0;
  slrh_top #(.P_BREAK_CYC(BRK), .P_ENQ_PERIOD_CYC(PER), .P_WINDOW_CYC(WIN),
    .P_RECOVERY_DIV(16'h0010), .P_BOOT_DIV(16'h0008)) dut_u (.i_clk(i_clk),
    .i_reset(i_reset), .i_rxd(i_rxd), .o_txd(o_txd), .i_tx_data(i_tx_data),
    .i_tx_valid(i_tx_valid), .o_tx_ready(o_tx_ready), .o_rx_data(o_rx_data),
    .o_rx_valid(o_rx_valid), .i_cfg_data(i_cfg_data), .i_cfg_valid(i_cfg_valid),
    .o_cfg_ready(o_cfg_ready), .i_baud_div(i_baud_div), .i_baud_load(i_baud_load),
    .o_baud_div(o_baud_div), .o_recovery(o_recovery));
  slrh_host host_u (.i_clk(i_clk), .i_txd(o_txd), .o_rxd(i_rxd));
  // ****
  // helpers
  // ****
  task automatic chk(input logic [15:0] seen, input logic [15:0] want);
    n_compared++;
    if (seen !== want) begin
      n_mismatch++;
      $display("unexpected at %0t: 0x%0h vs 0x%0h", $time, seen, want);
    end
  endtask : chk
  task automatic push(input logic [7:0] d, input bit cfg);
    i_tx_data <= d;
    i_cfg_data <= d;
    i_tx_valid <= !cfg;
    i_cfg_valid <= cfg;
    do @(posedge i_clk); while ((cfg ? o_cfg_ready : o_tx_ready) !== 1'b1);
    i_tx_valid <= 1'b0;
    i_cfg_valid <= 1'b0;
    exp_q.push_back(d);
    @(posedge i_clk);
  endtask : push
  task automatic drain();
    while (exp_q.size() > 0) begin
      wait (host_u.got.size() > 0);
      chk(16'(host_u.got.pop_front()), 16'(exp_q.pop_front()));
    end
  endtask : drain
  // one command byte closed by line feed, echoed on the user side
  task automatic talk(input logic [7:0] d);
    host_u.put(d);
    host_u.put(slrh_pkg::CHAR_LF);
    repeat (20) @(posedge i_clk);
    chk(16'(rx_q.pop_front()), 16'(d));
    chk(16'(rx_q.pop_front()), 16'(slrh_pkg::CHAR_LF));
  endtask : talk
  task automatic summarize();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : summarize
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  // tests take about 60k cycles; limit leaves a third spare
  initial begin
    #800_000;
    n_mismatch++;
    summarize();
  end
  always @(posedge i_clk) begin
    if (o_rx_valid === 1'b1) rx_q.push_back(o_rx_data);
    if (o_cfg_ready === 1'b1) n_cfg++;
  end
  // ****
  // tests
  // ****
  initial begin
    i_reset = 1'b1;
    i_tx_valid = 1'b0;
    i_cfg_valid = 1'b0;
    i_baud_load = 1'b0;
    i_tx_data = 8'h00;
    i_cfg_data = 8'h00;
    i_baud_div = 16'h0000;
    void'($urandom(32'h8526877e));
    repeat (3) @(posedge i_clk);
    i_reset <= 1'b0;
    repeat (3) push(8'($urandom), 1'b0);
    drain();
    b = 8'($urandom);
    talk(b);
    $display("normal traffic done");
    host_u.div = 16;
    host_u.brk(BRK * 5);
    chk(16'(o_recovery), 16'h0001);
    chk(o_baud_div, 16'h0010);
    wait (host_u.got.size() == 1);
    t0 = $time;
    wait (host_u.got.size() == 2);
    chk(16'(($time - t0) / 10), 16'(PER));
    repeat (2) exp_q.push_back(slrh_pkg::CHAR_ENQ);
    drain();
    host_u.put(slrh_pkg::CHAR_ACK);
    repeat (3) push(8'h20 + 8'($urandom_range(90)), 1'b1);
    push(slrh_pkg::CHAR_LF, 1'b1);
    drain();
    repeat (20) @(posedge i_clk);
    chk(16'(o_recovery), 16'h0000);
    chk(o_baud_div, 16'h0010);
    push(8'($urandom), 1'b0);
    drain();
    b = 8'($urandom);
    talk(b);
    $display("acknowledged recovery done");
    host_u.brk(BRK * 5);
    n = n_cfg;
    while (o_recovery === 1'b1) @(posedge i_clk);
    repeat (400) @(posedge i_clk);
    chk(16'(n_cfg - n), 16'h0000);
    n = host_u.got.size();
    chk(16'(n >= WIN / PER - 1 && n <= WIN / PER), 16'h0001);
    repeat (n) chk(16'(host_u.got.pop_front()), 16'(slrh_pkg::CHAR_ENQ));
    $display("window expiry done");
    repeat (3) push(8'($urandom), 1'b0);
    nd = 16'h0008 + 16'($urandom_range(7));
    i_baud_div <= nd;
    i_baud_load <= 1'b1;
    @(posedge i_clk);
    i_baud_load <= 1'b0;
    @(posedge i_clk);
    chk(o_baud_div, 16'h0010);
    drain();
    for (int i = 0; i < 40 && o_baud_div !== nd; i++) @(posedge i_clk);
    chk(o_baud_div, nd);
    host_u.div = int'(nd);
    push(8'($urandom), 1'b0);
    drain();
    $display("rate change done");
    summarize();
  end
endmodule : test_serial_link_recovery_handshake
`default_nettype wire
